// ---- fxcq_pkg.sv ----
// shared constants, carriers and helpers of the correlator quadrant
package fxcq_pkg;
  localparam int LOG2_FFT = 20;
  localparam int NUM_LANE = 8;
  localparam int NUM_ANT = 16;
  localparam int NUM_WIN = 4;
  localparam int BAND_MHZ = 2000;
  localparam real CHAN_KHZ = 3.815;
  localparam int SMP_W = 3;
  localparam int VS_W = 16;
  localparam int RQ_W = 4;
  localparam int TW_W = 8;
  localparam int ACC_W = 40;
  localparam int VS_SHIFT = 8;
  localparam int LANE_SHIFT = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int CHAN_W = LOG2_FFT - 1;
  localparam int BIN_W = 12;
  localparam int TAG_W = 4;
  localparam int ANT_W = $clog2(NUM_ANT);
  localparam int STR_W = ANT_W + 1;
  localparam int WIN_W = $clog2(NUM_WIN);
  localparam int LANE_W = $clog2(NUM_LANE);
  localparam logic signed [ACC_W-1:0] VS_MAX = ACC_W'(16'sh7FFF);
  localparam logic signed [ACC_W-1:0] VS_MIN = ACC_W'(16'sh8000);

  typedef struct packed {
    logic [STR_W-1:0] strm;
    logic [TAG_W-1:0] frame;
    logic [CHAN_W-1:0] chan;
    logic [RQ_W-1:0] re;
    logic [RQ_W-1:0] im;
  } fxcq_spec_t;

  typedef struct packed {
    logic en;
    logic [CHAN_W-1:0] start;
    logic [BIN_W-1:0] nbins;
    logic [2:0] bin_log2;
  } fxcq_win_t;

  typedef struct packed {
    logic [WIN_W-1:0] win;
    logic [ANT_W-1:0] ant_a;
    logic [ANT_W-1:0] ant_b;
    logic pol_a;
    logic pol_b;
    logic [BIN_W-1:0] bin;
    logic [31:0] re;
    logic [31:0] im;
  } fxcq_res_t;

  // odd levels -7..7 of a 3-bit sample code
  function automatic logic signed [4:0] fxcq_level(input logic [SMP_W-1:0] c);
    return $signed({1'b0, c, 1'b1}) - 5'sh08;
  endfunction

  function automatic logic signed [TW_W-1:0] fxcq_cos(input logic [3:0] i);
    case (i)
      4'h0: return 8'sh7F;
      4'h1, 4'hF: return 8'sh75;
      4'h2, 4'hE: return 8'sh5A;
      4'h3, 4'hD: return 8'sh31;
      4'h4, 4'hC: return 8'sh00;
      4'h5, 4'hB: return 8'shCF;
      4'h6, 4'hA: return 8'shA6;
      4'h7, 4'h9: return 8'sh8B;
      default: return 8'sh81;
    endcase
  endfunction

  function automatic logic [VS_W-1:0] fxcq_sat16(input logic signed [ACC_W-1:0] a);
    logic signed [ACC_W-1:0] s;
    s = a >>> VS_SHIFT;
    if (s > VS_MAX) return VS_MAX[VS_W-1:0];
    if (s < VS_MIN) return VS_MIN[VS_W-1:0];
    return s[VS_W-1:0];
  endfunction

  function automatic logic [STR_W:0] fxcq_streams(input logic [NUM_ANT-1:0] en);
    logic [STR_W:0] n;
    n = '0;
    for (int a = 0; a < NUM_ANT; a++) n = n + {{STR_W{1'b0}}, en[a]};
    return n << 1;
  endfunction

  function automatic logic [LANE_W-1:0] fxcq_pick(input logic [NUM_LANE-1:0] m);
    logic [LANE_W-1:0] p;
    p = '0;
    for (int g = NUM_LANE - 1; g >= 0; g--) if (m[g]) p = LANE_W'(g);
    return p;
  endfunction
endpackage

// ---- fxcq_fifo.sv ----
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module fxcq_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
)(
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire same = wr_ptr[AW-1:0] == rd_ptr[AW-1:0];
  wire full = same && (wr_ptr[AW] != rd_ptr[AW]);
  wire empty = wr_ptr == rd_ptr;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk_sys) begin
    if (in_valid && !full) mem[wr_ptr[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) wr_ptr <= wr_ptr + 1'b1;
      if (out_ready && !empty) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- fxcq_lane.sv ----
// one time-slice lane: frame capture, transform, requantizer
`timescale 1ns/100ps
`default_nettype none
module fxcq_lane
  import fxcq_pkg::*;
#(
  parameter int LOG2_N = LOG2_FFT
)(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [SMP_W-1:0]  in_code,
  input  wire logic [STR_W-1:0]  in_strm,
  input  wire logic [TAG_W-1:0]  in_frame,
  input  wire logic [LOG2_N-1:0] in_delay,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output fxcq_spec_t             out_spec
);
  typedef enum {L_LOAD, L_CALC, L_OUT} fxcq_lst_t;
  fxcq_lst_t state;
  logic [SMP_W-1:0] frame_mem [2**LOG2_N];
  logic [LOG2_N-1:0] n;
  logic [LOG2_N-1:0] k;
  logic [LOG2_N-1:0] phase;
  logic [LOG2_N-1:0] delay;
  logic [STR_W-1:0] strm;
  logic [TAG_W-1:0] frame;
  logic signed [ACC_W-1:0] acc_re;
  logic signed [ACC_W-1:0] acc_im;
  wire in_take = in_valid && in_ready;
  wire [LOG2_N-1:0] rd_addr = n + delay;
  wire signed [4:0] lvl = fxcq_level(frame_mem[rd_addr]);
  wire [3:0] ph = phase[LOG2_N-1 -: 4];
  wire signed [12:0] m_re = lvl * fxcq_cos(ph);
  wire signed [12:0] m_im = lvl * fxcq_cos(ph - 4'h4);
  wire signed [ACC_W-1:0] next_re = acc_re + ACC_W'(m_re);
  wire signed [ACC_W-1:0] next_im = acc_im - ACC_W'(m_im);
  wire [VS_W-1:0] vs_re = fxcq_sat16(next_re);
  wire [VS_W-1:0] vs_im = fxcq_sat16(next_im);
  wire k_last = k == {1'b0, {(LOG2_N-1){1'b1}}};
  assign in_ready = state == L_LOAD;
  assign out_valid = state == L_OUT;
  always_ff @(posedge clk_sys) begin
    if (in_take) frame_mem[n] <= in_code;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= L_LOAD;
      n <= '0;
      k <= '0;
      phase <= '0;
      delay <= '0;
      strm <= '0;
      frame <= '0;
      acc_re <= '0;
      acc_im <= '0;
      out_spec <= '0;
    end else begin
      case (state)
        L_LOAD: if (in_take) begin
          n <= n + 1'b1;
          if (n == '0) begin
            strm <= in_strm;
            frame <= in_frame;
            delay <= in_delay;
          end
          if (n == '1) begin
            state <= L_CALC;
            k <= '0;
          end
        end
        L_CALC: begin
          n <= n + 1'b1;
          phase <= phase + k;
          acc_re <= next_re;
          acc_im <= next_im;
          if (n == '1) begin
            state <= L_OUT;
            out_spec.strm <= strm;
            out_spec.frame <= frame;
            out_spec.chan <= CHAN_W'(k);
            out_spec.re <= vs_re[VS_W-1 -: RQ_W];
            out_spec.im <= vs_im[VS_W-1 -: RQ_W];
          end
        end
        L_OUT: if (out_ready) begin
          acc_re <= '0;
          acc_im <= '0;
          phase <= '0;
          k <= k + 1'b1;
          state <= k_last ? L_LOAD : L_CALC;
        end
        default: state <= L_LOAD;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- fxcq_quadrant.sv ----
// top of one correlator quadrant: lanes, correlator, integrator
`timescale 1ns/100ps
`default_nettype none
// How it works
// - transform yields 2^19 channels, 3.815 kHz apart
// - both polarizations of every connected antenna
// - frames sliced round robin over eight lanes
// - delay-align samples, then 2^20-point transform
// - image sideband half never produced
// - 16-bit voltage spectra requantized to 4 bits
// - transform consumes 3-bit digitizer samples
// - trim to window, multiply pair spectra
// - autos use the same multiplier path
// - cross-polarization products only when enabled
// - channel-averaged, time-integrated results leave
// - results also divided by eight, the lane count
// - each window placed anywhere in spectrum
module fxcq_quadrant
  import fxcq_pkg::*;
#(
  parameter int LOG2_N = LOG2_FFT
)(
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire logic                  smp_valid,
  output logic                       smp_ready,
  input  wire logic [STR_W-1:0]      smp_strm,
  input  wire logic [SMP_W-1:0]      smp_code,
  input  wire logic [NUM_ANT-1:0]    ant_enable,
  input  wire logic                  xpol_enable,
  input  wire logic [NUM_ANT-1:0]
                    [LOG2_N-1:0]     delay_cfg,
  input  wire fxcq_win_t [NUM_WIN-1:0] win_cfg,
  input  wire logic [15:0]           integ_frames,
  output logic                       res_valid,
  input  wire logic                  res_ready,
  output fxcq_res_t                  res,
  output logic                       corr_busy,
  output logic [NUM_LANE-1:0]        lane_busy,
  output logic [15:0]                integ_count
);
  localparam int SPEC_W = $bits(fxcq_spec_t);
  localparam int FW = STR_W + LOG2_N;
  localparam int SA_W = STR_W + LOG2_N - 1;
  localparam int IX_W = WIN_W + 2 * ANT_W + 2 + BIN_W;

  // ****************************************
  // reset release
  // ****************************************
  // release takes two edges
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // sample dispatch to lanes
  // ****************************************
  logic [LOG2_N-1:0] blk_cnt;
  logic [LANE_W-1:0] lane_sel;
  logic [STR_W:0] blk_in_frame;
  logic [TAG_W-1:0] in_frame;
  logic [NUM_LANE-1:0] lane_ir;
  // stream id is antenna and polarization of this baseband
  wire [ANT_W-1:0] smp_ant = smp_strm[STR_W-1:1];
  wire smp_keep = ant_enable[smp_ant];
  // disabled streams skip lanes
  wire smp_take = smp_valid && smp_ready;
  wire blk_end = smp_take && smp_keep && (blk_cnt == '1);
  wire [STR_W:0] n_strm = fxcq_streams(ant_enable);
  wire frame_end = blk_in_frame == n_strm - 1'b1;

  assign smp_ready = !smp_keep || lane_ir[lane_sel];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blk_cnt <= '0;
      lane_sel <= '0;
      blk_in_frame <= '0;
      in_frame <= '0;
    end else if (smp_take && smp_keep) begin
      blk_cnt <= blk_cnt + 1'b1;
      if (blk_end) begin
        lane_sel <= lane_sel + 1'b1;
        if (frame_end) begin
          blk_in_frame <= '0;
          in_frame <= in_frame + 1'b1;
        end else begin
          blk_in_frame <= blk_in_frame + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // transform lanes
  // ****************************************
  fxcq_spec_t lane_spec [NUM_LANE];
  logic [NUM_LANE-1:0] lane_ov;
  logic [NUM_LANE-1:0] lane_hit;
  logic [NUM_LANE-1:0] lane_or;
  logic [TAG_W-1:0] out_frame;
  logic fifo_ir;
  // lowest lane wins
  wire [LANE_W-1:0] lane_pick = fxcq_pick(lane_hit);

  for (genvar g = 0; g < NUM_LANE; g++) begin : g_lane
    wire sel = lane_sel == LANE_W'(g);
    fxcq_lane #(
      .LOG2_N (LOG2_N)
    ) u_lane (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (smp_valid && smp_keep && sel),
      .in_ready  (lane_ir[g]),
      .in_code   (smp_code),
      .in_strm   (smp_strm),
      .in_frame  (in_frame),
      .in_delay  (delay_cfg[smp_ant]),
      .out_valid (lane_ov[g]),
      .out_ready (lane_or[g]),
      .out_spec  (lane_spec[g])
    );
    // only the frame being gathered may enter the buffer
    assign lane_hit[g] = lane_ov[g] && (lane_spec[g].frame == out_frame);
    assign lane_or[g] = fifo_ir && lane_hit[g] && (lane_pick == LANE_W'(g));
    assign lane_busy[g] = !lane_ir[g];
  end

  // ****************************************
  // voltage spectrum buffer
  // ****************************************
  logic fifo_ov;
  logic fifo_or;
  logic [SPEC_W-1:0] fifo_data;
  fxcq_fifo #(
    .W     (SPEC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (|lane_hit),
    .in_ready  (fifo_ir),
    .in_data   (lane_spec[lane_pick]),
    .out_valid (fifo_ov),
    .out_ready (fifo_or),
    .out_data  (fifo_data)
  );

  fxcq_spec_t fifo_out;
  assign fifo_out = fxcq_spec_t'(fifo_data);

  // ****************************************
  // spectrum store, one frame of all streams
  // ****************************************
  typedef enum {C_FILL, C_CORR, C_DUMP} fxcq_cst_t;
  fxcq_cst_t state;
  logic [2*RQ_W-1:0] spec_mem [2**SA_W];
  // one word per stream, channel
  logic [FW-1:0] fill_cnt;
  wire [FW-1:0] fill_all = {n_strm, {(LOG2_N-1){1'b0}}};
  wire [FW-1:0] fill_last = fill_all - 1'b1;
  assign fifo_or = state == C_FILL;
  wire fill_take = fifo_ov && fifo_or;
  wire fill_done = fill_take && (fill_cnt == fill_last);
  wire [SA_W-1:0] fill_addr = {fifo_out.strm, fifo_out.chan[LOG2_N-2:0]};
  always_ff @(posedge clk_sys) begin
    if (fill_take) spec_mem[fill_addr] <= {fifo_out.re, fifo_out.im};
  end

  // ****************************************
  // sweep over windows, channels, pairs
  // ****************************************
  logic [WIN_W-1:0] w;
  logic [CHAN_W-1:0] c;
  logic [ANT_W-1:0] i;
  logic [ANT_W-1:0] j;
  logic [1:0] q;
  fxcq_win_t wc;
  assign wc = win_cfg[w];
  wire dump = state == C_DUMP;
  wire [15:0] span = {4'h0, wc.nbins} << wc.bin_log2;
  wire [CHAN_W-1:0] c_lim = dump ? CHAN_W'(wc.nbins) : CHAN_W'(span);
  // q walks XX, YY, then XY, YX
  wire pol_a = q[0];
  wire pol_b = q[0] ^ q[1];
  wire q_last = q == (xpol_enable ? 2'h3 : 2'h1);
  wire j_last = j == ANT_W'(NUM_ANT - 1);
  wire i_last = i == ANT_W'(NUM_ANT - 1);
  wire c_last = (c_lim == '0) || (c == c_lim - 1'b1);
  wire w_last = w == WIN_W'(NUM_WIN - 1);
  wire sweep_end = q_last && j_last && i_last && c_last && w_last;

  wire pair_ok = ant_enable[i] && ant_enable[j] && (j >= i);
  wire act = wc.en && (c_lim != '0) && pair_ok;

  logic res_load;
  wire out_free = !res_valid || res_ready;
  wire step = (state == C_CORR) || (dump && (!act || out_free));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      j <= '0;
      i <= '0;
      c <= '0;
      w <= '0;
    end else if (step && state != C_FILL) begin
      q <= q_last ? 2'h0 : q + 2'h1;
      if (q_last) begin
        j <= j + 1'b1;
        if (j_last) begin
          i <= i + 1'b1;
          if (i_last) begin
            c <= c_last ? '0 : c + 1'b1;
            if (c_last) w <= w_last ? '0 : w + 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // cross multiply
  // ****************************************
  wire [CHAN_W-1:0] ch = wc.start + c;
  wire [SA_W-1:0] a_addr = {i, pol_a, ch[LOG2_N-2:0]};
  wire [SA_W-1:0] b_addr = {j, pol_b, ch[LOG2_N-2:0]};

  wire [2*RQ_W-1:0] va = spec_mem[a_addr];
  wire [2*RQ_W-1:0] vb = spec_mem[b_addr];
  // high nibble is the real part
  wire signed [RQ_W-1:0] ar = va[2*RQ_W-1:RQ_W];
  wire signed [RQ_W-1:0] ai = va[RQ_W-1:0];
  wire signed [RQ_W-1:0] br = vb[2*RQ_W-1:RQ_W];
  wire signed [RQ_W-1:0] bi = vb[RQ_W-1:0];
  // a times conjugate of b; i equal to j gives the auto spectrum
  wire signed [2*RQ_W:0] p_re = ar * br + ai * bi;
  wire signed [2*RQ_W:0] p_im = ai * br - ar * bi;

  // ****************************************
  // time integration
  // ****************************************
  logic signed [ACC_W-1:0] integ_re [2**IX_W];
  logic signed [ACC_W-1:0] integ_im [2**IX_W];
  wire [CHAN_W-1:0] bin_c = c >> wc.bin_log2;
  wire [BIN_W-1:0] bin = dump ? c[BIN_W-1:0] : bin_c[BIN_W-1:0];
  wire [IX_W-1:0] ix = {w, i, j, q, bin};
  wire [CHAN_W-1:0] bin_mask = ~({CHAN_W{1'b1}} << wc.bin_log2);
  wire bin_first = (c & bin_mask) == '0;

  wire first = (integ_count == 16'h0) && bin_first;
  wire integ_wr = (state == C_CORR) && act;
  wire signed [ACC_W-1:0] add_re = ACC_W'(p_re);
  wire signed [ACC_W-1:0] add_im = ACC_W'(p_im);
  wire signed [ACC_W-1:0] sum_re = integ_re[ix] + add_re;
  wire signed [ACC_W-1:0] sum_im = integ_im[ix] + add_im;
  always_ff @(posedge clk_sys) begin
    if (integ_wr) begin
      integ_re[ix] <= first ? add_re : sum_re;
      integ_im[ix] <= first ? add_im : sum_im;
    end
  end
  // zero frames acts as one
  wire integ_last = (integ_frames == 16'h0) ||
                    (integ_count == integ_frames - 16'h1);

  // ****************************************
  // frame sequencing
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= C_FILL;
      fill_cnt <= '0;
      out_frame <= '0;
      integ_count <= 16'h0;
    end else begin
      case (state)
        C_FILL: if (fill_take) begin
          fill_cnt <= fill_done ? '0 : fill_cnt + 1'b1;
          if (fill_done) begin
            state <= C_CORR;
            out_frame <= out_frame + 1'b1;
          end
        end
        C_CORR: if (sweep_end) begin
          if (integ_last) begin
            integ_count <= 16'h0;
            state <= C_DUMP;
          end else begin
            integ_count <= integ_count + 16'h1;
            state <= C_FILL;
          end
        end
        C_DUMP: if (step && sweep_end) state <= C_FILL;
        default: state <= C_FILL;
      endcase
    end
  end

  assign corr_busy = state != C_FILL;

  // ****************************************
  // result output
  // ****************************************
  // divide by bin width and by the lane count
  wire [3:0] out_sh = {1'b0, wc.bin_log2} + 4'(LANE_SHIFT);
  wire signed [ACC_W-1:0] avg_re = integ_re[ix] >>> out_sh;
  wire signed [ACC_W-1:0] avg_im = integ_im[ix] >>> out_sh;

  assign res_load = dump && act && out_free;

  // held until the consumer takes it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res <= '0;
    end else if (res_load) begin
      res_valid <= 1'b1;
      res.win <= w;
      res.ant_a <= i;
      res.ant_b <= j;
      res.pol_a <= pol_a;
      res.pol_b <= pol_b;
      res.bin <= bin;
      res.re <= avg_re[31:0];
      res.im <= avg_im[31:0];
    end else if (res_ready) begin
      res_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- fxcq_quadrant_sva.sv ----
// port checker of the correlator quadrant
`timescale 1ns/100ps
`default_nettype none
module fxcq_quadrant_chk
  import fxcq_pkg::*;
(
  input wire logic                    clk_sys,
  input wire logic                    resetn,
  input wire logic                    smp_valid,
  input wire logic                    smp_ready,
  input wire logic [STR_W-1:0]        smp_strm,
  input wire logic [NUM_ANT-1:0]      ant_enable,
  input wire logic                    xpol_enable,
  input wire fxcq_win_t [NUM_WIN-1:0] win_cfg,
  input wire logic [15:0]             integ_frames,
  input wire logic                    res_valid,
  input wire logic                    res_ready,
  input wire fxcq_res_t               res,
  input wire logic [NUM_LANE-1:0]     lane_busy,
  input wire logic [15:0]             integ_count
);
  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  wire logic ant_on = ant_enable[smp_strm[STR_W-1:1]];
  sequence s_stalled;
    res_valid && !res_ready;
  endsequence
  sequence s_kept;
    res_valid && $stable(res);
  endsequence
  a_res_held: assert property (s_stalled |=> s_kept)
    else $error("result changed while stalled");
  a_drop_disabled: assert property (smp_valid && !ant_on |-> smp_ready)
    else $error("disabled stream sample refused");
  a_lane_refuse: assert property (
    smp_valid && ant_on && !smp_ready |-> lane_busy != '0)
    else $error("sample refused with all lanes free");
  a_xpol_gate: assert property (
    res_valid && !xpol_enable |-> res.pol_a == res.pol_b)
    else $error("cross polarization result while disabled");
  a_pair_upper: assert property (res_valid |-> res.ant_b >= res.ant_a)
    else $error("pair order wrong");
  a_pair_enabled: assert property (
    res_valid |-> ant_enable[res.ant_a] && ant_enable[res.ant_b])
    else $error("result for a disabled antenna");
  a_win_bin_ok: assert property (res_valid |-> win_cfg[res.win].en
    && res.bin < win_cfg[res.win].nbins)
    else $error("result outside an enabled window");
  a_count_bound: assert property (
    integ_frames != 16'h0000 |-> integ_count < integ_frames)
    else $error("frame count past period");
  a_count_step: assert property (integ_count != $past(integ_count)
    |-> integ_count == $past(integ_count) + 16'h0001
    || integ_count == 16'h0000)
    else $error("frame count jumped");
endmodule
bind fxcq_quadrant fxcq_quadrant_chk u_fxcq_quadrant_chk (
  .clk_sys(clk_sys), .resetn(resetn), .smp_valid(smp_valid),
  .smp_ready(smp_ready), .smp_strm(smp_strm), .ant_enable(ant_enable),
  .xpol_enable(xpol_enable), .win_cfg(win_cfg),
  .integ_frames(integ_frames), .res_valid(res_valid),
  .res_ready(res_ready), .res(res), .lane_busy(lane_busy),
  .integ_count(integ_count)
);
`default_nettype wire

// ---- fxcq_sender.sv ----
// upstream sample sender: one block per enabled stream per frame, after a stream 5'h1F block when junk is set
`timescale 1ns/100ps
`default_nettype none
module fxcq_sender
  import fxcq_pkg::*;
#(
  parameter int LOG2_N = 4
)(
  input  wire logic               clk_sys,
  input  wire logic               go,
  input  wire logic [NUM_ANT-1:0] ant_en,
  input  wire logic [15:0]        nframes,
  input  wire logic [SMP_W-1:0]   code,
  input  wire logic               junk,
  input  wire logic               stall,
  output logic                    smp_valid,
  input  wire logic               smp_ready,
  output logic [STR_W-1:0]        smp_strm,
  output logic [SMP_W-1:0]        smp_code
);
  // ***************************************************************
  // block transfer
  // ***************************************************************
  logic rdy_seen;
  // ready settles before the taking edge
  always @(negedge clk_sys) rdy_seen <= smp_ready;
  task automatic put(input logic [STR_W-1:0] s);
    for (int n = 0; n < (1 << LOG2_N); n++) begin
      smp_valid <= 1'b1;
      smp_strm <= s;
      smp_code <= code;
      @(posedge clk_sys);
      while (rdy_seen !== 1'b1) @(posedge clk_sys);
      if (stall) begin
        smp_valid <= 1'b0;
        smp_code <= ~code;
        @(posedge clk_sys);
      end
    end
  endtask
  initial begin
    smp_valid = 1'b0;
    smp_strm = '0;
    smp_code = '0;
    forever begin
      @(posedge clk_sys);
      if (go === 1'b1) begin
        for (int f = 0; f < ((nframes == 0) ? 1 : nframes); f++) begin
          if (junk) put(5'h1F);
          for (int a = 0; a < NUM_ANT; a++) begin
            if (ant_en[a]) begin
              put({a[3:0], 1'b0});
              put({a[3:0], 1'b1});
            end
          end
        end
        smp_valid <= 1'b0;
        smp_strm <= ~smp_strm;
        smp_code <= ~code;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb_fxcq_quadrant.sv ----
// self-checking bench of the correlator quadrant
`timescale 1ns/100ps
`default_nettype none
module tb_fxcq_quadrant;
  import fxcq_pkg::*;
  // ***************************************************************
  // stimulus and checks
  // ***************************************************************
  localparam int LN = 4;
  typedef struct packed {
    logic [NUM_ANT-1:0] ant;
    logic               xpol;
    logic [15:0]        frames;
    logic [SMP_W-1:0]   code;
    logic               junk;
    logic               stall;
    fxcq_win_t          w0;
    fxcq_win_t          w1;
  } fxcq_row_t;
  logic clk_sys, resetn, smp_valid, smp_ready, xpol_enable, res_valid;
  logic res_ready, corr_busy, go, junk, stall;
  logic [STR_W-1:0] smp_strm;
  logic [SMP_W-1:0] smp_code, code;
  logic [NUM_ANT-1:0] ant_enable;
  logic [NUM_ANT-1:0][LN-1:0] delay_cfg;
  fxcq_win_t [NUM_WIN-1:0] win_cfg;
  logic [15:0] integ_frames, integ_count;
  logic [NUM_LANE-1:0] lane_busy;
  fxcq_res_t res;
  fxcq_res_t exp_q[$];
  logic [31:0] cyc = '0;
  int err_total = 0;
  int check_count = 0;
  // constant positive codes requantize below one step, so products are 0
  fxcq_row_t rows [4] = '{
    '{16'h0001, 1'b0, 16'h0001, 3'h4, 1'b0, 1'b0,
      '{1'b1, 19'h0, 12'h001, 3'h0}, '0},
    '{16'h0005, 1'b1, 16'h0002, 3'h7, 1'b1, 1'b1,
      '{1'b1, 19'h0, 12'h002, 3'h2}, '0},
    '{16'h8001, 1'b0, 16'h0001, 3'h5, 1'b0, 1'b0,
      '{1'b1, 19'h0, 12'h008, 3'h0}, '{1'b1, 19'h4, 12'h002, 3'h1}},
    '{16'h0002, 1'b0, 16'h0000, 3'h6, 1'b0, 1'b1,
      '{1'b1, 19'h2, 12'h003, 3'h1}, '0}};
  fxcq_quadrant #(.LOG2_N(LN)) u_fxcq_quadrant (
    .clk_sys(clk_sys), .resetn(resetn), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .smp_strm(smp_strm), .smp_code(smp_code),
    .ant_enable(ant_enable), .xpol_enable(xpol_enable),
    .delay_cfg(delay_cfg), .win_cfg(win_cfg),
    .integ_frames(integ_frames), .res_valid(res_valid),
    .res_ready(res_ready), .res(res), .corr_busy(corr_busy),
    .lane_busy(lane_busy), .integ_count(integ_count));
  fxcq_sender #(.LOG2_N(LN)) u_fxcq_sender (
    .clk_sys(clk_sys), .go(go), .ant_en(ant_enable),
    .nframes(integ_frames), .code(code), .junk(junk), .stall(stall),
    .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_strm(smp_strm), .smp_code(smp_code));
  task automatic check(input logic [127:0] seen, input logic [127:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    res_ready <= (cyc % 3) != 0;
  end
  always @(negedge clk_sys) begin
    if (res_valid === 1'b1 && res_ready === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else check(res, exp_q.pop_front());
    end
  end
  task automatic run_row(input fxcq_row_t r);
    fxcq_res_t e;
    fxcq_win_t wc;
    int n;
    @(posedge clk_sys);
    ant_enable <= r.ant;
    xpol_enable <= r.xpol;
    integ_frames <= r.frames;
    code <= r.code;
    junk <= r.junk;
    stall <= r.stall;
    win_cfg <= {fxcq_win_t'('0), fxcq_win_t'('0), r.w1, r.w0};
    for (int w = 0; w < 2; w++) begin
      wc = w ? r.w1 : r.w0;
      if (wc.en)
        for (int b = 0; b < wc.nbins; b++)
          for (int a = 0; a < NUM_ANT; a++)
            for (int c = a; c < NUM_ANT; c++)
              if (r.ant[a] && r.ant[c])
                for (int q = 0; q < (r.xpol ? 4 : 2); q++) begin
                  e = '0;
                  e.win = WIN_W'(w);
                  e.ant_a = ANT_W'(a);
                  e.ant_b = ANT_W'(c);
                  e.bin = BIN_W'(b);
                  e.pol_a = (q == 1 || q == 3);
                  e.pol_b = (q == 1 || q == 2);
                  exp_q.push_back(e);
                end
    end
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    n = 0;
    while ((exp_q.size() != 0 || corr_busy !== 1'b0) && n < 40000) begin
      @(negedge clk_sys);
      n++;
    end
    check(exp_q.size(), 0);
    check(integ_count, 16'h0000);
    exp_q.delete();
  endtask
  initial begin
    resetn = 1'b0;
    go = 1'b0;
    code = '0;
    junk = 1'b0;
    stall = 1'b0;
    ant_enable = '0;
    xpol_enable = 1'b0;
    win_cfg = '0;
    integ_frames = '0;
    for (int a = 0; a < NUM_ANT; a++) delay_cfg[a] = LN'(a);
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (rows[i]) run_row(rows[i]);
    @(posedge clk_sys);
    resetn <= 1'b0;
    @(negedge clk_sys);
    check(smp_ready, 1'b1);
    check(res_valid, 1'b0);
    check(lane_busy, 8'h00);
    check(corr_busy, 1'b0);
    check(integ_count, 16'h0000);
    @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    run_row(rows[1]);
    conclude();
  end
  initial begin
    #500000;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
